// >>> hdl/ldo_power_sequencer.sv
// control logic of a seven-regulator power sequencer
// assumes an external bus engine on clk_sys_i issuing single-cycle register strobes,
// and analog detectors whose flags arrive asynchronously
`timescale 1ns/1ns
`default_nettype none

module ldo_power_sequencer #(
  parameter int NUM_REG = 7,
  parameter int STEP_CYCLES = ldo_seq_pkg::SLOT_STEP_CYCLES
) (
  // clock and reset (reset is the active-low enable pin, already clean)
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // register port from the bus engine
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic bus_active_o,
  // analog monitor flags, asynchronous
  input wire logic por_ok_i,
  input wire logic sys_uv_i,
  input wire logic [NUM_REG-1:0] vin_uv_i,
  input wire logic overcurrent_i,
  input wire logic overtemp_i,
  // regulator controls
  output logic [NUM_REG-1:0] regulator_en_o,
  output logic [NUM_REG-1:0] discharge_en_o,
  output logic [7:0] uv_threshold_o,
  output logic [2:0] slot_counter_o,
  output logic irq_o
);

  localparam int NSYNC = NUM_REG + 4;
  localparam int STEP_W = $clog2(STEP_CYCLES + 1);

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [NSYNC-1:0] next_sync_a;
  logic por_ok;
  logic sys_uv;
  logic [NUM_REG-1:0] vin_uv;
  logic overcurrent;
  logic overtemp;

  always_comb begin
    next_sync_a = {por_ok_i, sys_uv_i, overcurrent_i, overtemp_i, vin_uv_i};
  end

  always_ff @(posedge clk_sys_i) begin
    sync_a <= next_sync_a;
    sync_b <= sync_a;
  end

  assign por_ok = sync_b[NSYNC-1];
  assign sys_uv = sync_b[NSYNC-2];
  assign overcurrent = sync_b[NSYNC-3];
  assign overtemp = sync_b[NSYNC-4];
  assign vin_uv = sync_b[NUM_REG-1:0];

  // ****************************************
  // register file
  // ****************************************
  logic [7:0] discharge_disable;
  logic [7:0] regulator_enable_ctrl;
  logic [7:0] fault_interrupt_mask;
  logic [7:0] fault_latched_status;
  logic [7:0] supply_undervolt_threshold;
  logic [1:0] seq_run_ctrl;
  logic [3:0] regulator_slot_sel [NUM_REG];
  logic [7:0] next_discharge_disable;
  logic [7:0] next_regulator_enable_ctrl;
  logic [7:0] next_fault_interrupt_mask;
  logic [7:0] next_supply_undervolt_threshold;
  logic [1:0] next_seq_run_ctrl;
  logic [3:0] next_regulator_slot_sel [NUM_REG];
  logic [7:0] next_rdata;
  logic next_bus_active;
  logic wr_ok;

  // writes are dropped until the supply monitor reports power good
  assign wr_ok = reg_wr_i & bus_active_o;

  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  always_comb begin
    next_bus_active = por_ok;
    next_discharge_disable = discharge_disable;
    next_regulator_enable_ctrl = regulator_enable_ctrl;
    next_fault_interrupt_mask = fault_interrupt_mask;
    next_supply_undervolt_threshold = supply_undervolt_threshold;
    next_seq_run_ctrl = seq_run_ctrl;
    next_regulator_slot_sel = regulator_slot_sel;
    next_rdata = 8'h00;
    if (wr_ok) begin
      if (is_addr(reg_addr_i, ldo_seq_pkg::ADDR_DISCHARGE_DISABLE)) begin
        next_discharge_disable = reg_wdata_i;
      end
      if (is_addr(reg_addr_i, ldo_seq_pkg::ADDR_REGULATOR_ENABLE_CTRL)) begin
        next_regulator_enable_ctrl = reg_wdata_i;
      end
      if (is_addr(reg_addr_i, ldo_seq_pkg::ADDR_FAULT_INTERRUPT_MASK)) begin
        next_fault_interrupt_mask = reg_wdata_i;
      end
      if (is_addr(reg_addr_i, ldo_seq_pkg::ADDR_SUPPLY_UNDERVOLT_THRESHOLD)) begin
        next_supply_undervolt_threshold = reg_wdata_i;
      end
      // only the two defined codes move the run level; others are ignored
      if (is_addr(reg_addr_i, ldo_seq_pkg::ADDR_SEQ_RUN_CTRL) &&
          (reg_wdata_i[1:0] == ldo_seq_pkg::SEQ_RUN_CTRL_STOP ||
           reg_wdata_i[1:0] == ldo_seq_pkg::SEQ_RUN_CTRL_RUN)) begin
        next_seq_run_ctrl = reg_wdata_i[1:0];
      end
      for (int i = 0; i < NUM_REG; i++) begin
        if (is_addr(reg_addr_i, ldo_seq_pkg::ADDR_SLOT_SEL_0 + 8'(i / 2))) begin
          next_regulator_slot_sel[i] = (i % 2 == 0) ? reg_wdata_i[3:0] :
                                       reg_wdata_i[7:4];
        end
      end
    end
    if (reg_rd_i && bus_active_o) begin
      case (reg_addr_i)
        ldo_seq_pkg::ADDR_DISCHARGE_DISABLE: next_rdata = discharge_disable;
        ldo_seq_pkg::ADDR_REGULATOR_ENABLE_CTRL: next_rdata = regulator_enable_ctrl;
        ldo_seq_pkg::ADDR_SEQ_RUN_CTRL: next_rdata = {6'h00, seq_run_ctrl};
        ldo_seq_pkg::ADDR_FAULT_INTERRUPT_MASK: next_rdata = fault_interrupt_mask;
        ldo_seq_pkg::ADDR_FAULT_LATCHED_STATUS: next_rdata = fault_latched_status;
        ldo_seq_pkg::ADDR_SUPPLY_UNDERVOLT_THRESHOLD: next_rdata = supply_undervolt_threshold;
        default: next_rdata = 8'h00;
      endcase
      for (int i = 0; i < NUM_REG; i++) begin
        if (is_addr(reg_addr_i, ldo_seq_pkg::ADDR_SLOT_SEL_0 + 8'(i / 2))) begin
          if (i % 2 == 0) begin
            next_rdata[3:0] = regulator_slot_sel[i];
          end else begin
            next_rdata[7:4] = regulator_slot_sel[i];
          end
        end
      end
    end
  end

  // the enable pin is the synchronous reset: every register but the input synchronisers returns to default
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      bus_active_o <= 1'b0;
      reg_rdata_o <= 8'h00;
      discharge_disable <= ldo_seq_pkg::RST_DISCHARGE_DISABLE;
      regulator_enable_ctrl <= ldo_seq_pkg::RST_REGULATOR_ENABLE_CTRL;
      fault_interrupt_mask <= ldo_seq_pkg::RST_FAULT_INTERRUPT_MASK;
      supply_undervolt_threshold <= ldo_seq_pkg::RST_SUPPLY_UNDERVOLT_THRESHOLD;
      seq_run_ctrl <= ldo_seq_pkg::SEQ_RUN_CTRL_STOP;
      for (int i = 0; i < NUM_REG; i++) begin
        regulator_slot_sel[i] <= ldo_seq_pkg::SLOT_DIRECT;
      end
    end else begin
      bus_active_o <= next_bus_active;
      reg_rdata_o <= next_rdata;
      discharge_disable <= next_discharge_disable;
      regulator_enable_ctrl <= next_regulator_enable_ctrl;
      fault_interrupt_mask <= next_fault_interrupt_mask;
      supply_undervolt_threshold <= next_supply_undervolt_threshold;
      seq_run_ctrl <= next_seq_run_ctrl;
      regulator_slot_sel <= next_regulator_slot_sel;
    end
  end

  // ****************************************
  // slot counter and sequencing
  // ****************************************
  logic seq_run;
  logic master_en;
  logic [STEP_W-1:0] step_cnt;
  logic [STEP_W-1:0] next_step_cnt;
  logic step_tick;
  logic [2:0] next_slot_counter;
  logic [NUM_REG-1:0] seq_state;
  logic [NUM_REG-1:0] next_seq_state;
  logic [NUM_REG-1:0] next_regulator_en;
  logic [NUM_REG-1:0] next_discharge_en;

  assign seq_run = (seq_run_ctrl == ldo_seq_pkg::SEQ_RUN_CTRL_RUN);
  assign master_en = regulator_enable_ctrl[ldo_seq_pkg::MASTER_EN_BIT];
  assign step_tick = (step_cnt == STEP_W'(STEP_CYCLES - 1));

  always_comb begin
    next_step_cnt = step_tick ? '0 : step_cnt + 1'b1;
    next_slot_counter = slot_counter_o;
    if (step_tick) begin
      if (seq_run && slot_counter_o != ldo_seq_pkg::SLOT_COUNT_MAX) begin
        next_slot_counter = slot_counter_o + 3'h1;
      end else if (!seq_run && slot_counter_o != ldo_seq_pkg::SLOT_COUNT_MIN) begin
        next_slot_counter = slot_counter_o - 3'h1;
      end
    end
    for (int i = 0; i < NUM_REG; i++) begin
      next_seq_state[i] = seq_state[i];
      if (regulator_slot_sel[i] == ldo_seq_pkg::SLOT_DIRECT) begin
        next_seq_state[i] = regulator_enable_ctrl[i];
      end else if ({1'b0, slot_counter_o} == regulator_slot_sel[i]) begin
        next_seq_state[i] = seq_run;
      end
      // supply and input monitors override; sequencer state is kept for recovery
      next_regulator_en[i] = next_seq_state[i] & master_en &
                             ~sys_uv & ~vin_uv[i];
      next_discharge_en[i] = ~next_regulator_en[i] & ~discharge_disable[i];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      step_cnt <= '0;
      slot_counter_o <= ldo_seq_pkg::SLOT_COUNT_MIN;
      seq_state <= '0;
      regulator_en_o <= '0;
      discharge_en_o <= '1;
      uv_threshold_o <= ldo_seq_pkg::RST_SUPPLY_UNDERVOLT_THRESHOLD;
    end else begin
      step_cnt <= next_step_cnt;
      slot_counter_o <= next_slot_counter;
      seq_state <= next_seq_state;
      regulator_en_o <= next_regulator_en;
      discharge_en_o <= next_discharge_en;
      uv_threshold_o <= supply_undervolt_threshold;
    end
  end

  // ****************************************
  // fault latch and interrupt
  // ****************************************
  logic master_en_q;
  logic [2:0] fault_raw;
  logic [2:0] fault_open;
  logic [2:0] capture;
  logic [7:0] next_status;
  logic next_irq;
  logic sw_disable_entry;
  logic [7:0] clear_bits;

  assign fault_raw = {overtemp, overcurrent, sys_uv};
  assign sw_disable_entry = master_en_q & ~master_en;
  assign clear_bits = (wr_ok && is_addr(reg_addr_i, ldo_seq_pkg::ADDR_FAULT_CLEAR)) ?
                      reg_wdata_i : 8'h00;

  always_comb begin
    // masked sources never reach the latch
    fault_open = fault_raw & ~fault_interrupt_mask[2:0] &
                 {3{~fault_interrupt_mask[ldo_seq_pkg::GLOBAL_MASK_BIT]}};
    // supply events count only while the port is alive; the synced monitor is used,
    // not the registered port flag, so gate and fault line up cycle for cycle
    fault_open[ldo_seq_pkg::FAULT_UV_BIT] = por_ok &
                                            fault_open[ldo_seq_pkg::FAULT_UV_BIT];
    capture = 3'h0;
    // one event at a time, fixed priority supply > current > temperature
    if (fault_latched_status[2:0] == 3'h0) begin
      if (fault_open[ldo_seq_pkg::FAULT_UV_BIT]) begin
        capture = 3'b001;
      end else if (fault_open[ldo_seq_pkg::FAULT_OC_BIT]) begin
        capture = 3'b010;
      end else if (fault_open[ldo_seq_pkg::FAULT_OT_BIT]) begin
        capture = 3'b100;
      end
    end
    next_status = (fault_latched_status & ~clear_bits) | {5'h00, capture};
    if (sw_disable_entry) begin
      next_status[ldo_seq_pkg::FAULT_UV_BIT] = 1'b1;
    end
    if (fault_interrupt_mask[ldo_seq_pkg::IRQ_PULSE_BIT]) begin
      next_irq = (capture != 3'h0) | sw_disable_entry;
    end else begin
      next_irq = (next_status != 8'h00);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      master_en_q <= 1'b1;
      fault_latched_status <= 8'h00;
      irq_o <= 1'b0;
    end else begin
      master_en_q <= master_en;
      fault_latched_status <= next_status;
      irq_o <= next_irq;
    end
  end

endmodule

`default_nettype wire

// >>> inc/ldo_seq_pkg.sv
// constants shared by the regulator sequencer and its bench
// assumes one 100 MHz system clock and an 8-bit register port from a bus engine
package ldo_seq_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_DISCHARGE_DISABLE = 8'h02;
  localparam logic [7:0] ADDR_REGULATOR_ENABLE_CTRL = 8'h0e;
  localparam logic [7:0] ADDR_SLOT_SEL_0 = 8'h10;
  localparam logic [7:0] ADDR_SEQ_RUN_CTRL = 8'h14;
  localparam logic [7:0] ADDR_FAULT_INTERRUPT_MASK = 8'h21;
  localparam logic [7:0] ADDR_FAULT_LATCHED_STATUS = 8'h22;
  localparam logic [7:0] ADDR_FAULT_CLEAR = 8'h23;
  localparam logic [7:0] ADDR_SUPPLY_UNDERVOLT_THRESHOLD = 8'h24;
  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int MASTER_EN_BIT = 7;
  localparam int FAULT_UV_BIT = 0;
  localparam int FAULT_OC_BIT = 1;
  localparam int FAULT_OT_BIT = 2;
  localparam int IRQ_PULSE_BIT = 6;
  localparam int GLOBAL_MASK_BIT = 7;
  localparam logic [7:0] RST_DISCHARGE_DISABLE = 8'h00;
  localparam logic [7:0] RST_REGULATOR_ENABLE_CTRL = 8'h80;
  localparam logic [7:0] RST_FAULT_INTERRUPT_MASK = 8'h00;
  localparam logic [7:0] RST_SUPPLY_UNDERVOLT_THRESHOLD = 8'h00;
  localparam logic [3:0] SLOT_DIRECT = 4'h0;
  localparam logic [1:0] SEQ_RUN_CTRL_STOP = 2'h0;
  localparam logic [1:0] SEQ_RUN_CTRL_RUN = 2'h1;
  localparam logic [2:0] SLOT_COUNT_MIN = 3'h0;
  localparam logic [2:0] SLOT_COUNT_MAX = 3'h7;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int SLOT_STEP_NS = 1000;
  localparam int SLOT_STEP_CYCLES = SLOT_STEP_NS / CLK_PERIOD_NS;
endpackage

// >>> testbench/ldo_power_sequencer_checker.sv
// concurrent checks on the sequencer's ports
// assumes one clock domain and the single-cycle register strobes of the port
`timescale 1ns/1ns
`default_nettype none
module ldo_power_sequencer_checker #(
  parameter int NUM_REG = 7
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic bus_active_o,
  // monitors and regulator side
  input wire logic por_ok_i,
  input wire logic sys_uv_i,
  input wire logic [NUM_REG-1:0] vin_uv_i,
  input wire logic [NUM_REG-1:0] regulator_en_o,
  input wire logic [NUM_REG-1:0] discharge_en_o,
  input wire logic [2:0] slot_counter_o,
  input wire logic irq_o
);
  // ****************
  // shadows of written control bits
  // ****************
  logic wr_ok;
  logic en_q;
  logic run_q;
  logic pulse_q;
  logic next_en;
  logic next_run;
  logic next_pulse;
  assign wr_ok = reg_wr_i && bus_active_o;
  always_comb begin
    next_en = en_q;
    next_run = run_q;
    next_pulse = pulse_q;
    if (wr_ok && reg_addr_i == 8'h0e)
      next_en = reg_wdata_i[7];
    // codes other than stop and run leave the sequencer alone
    if (wr_ok && reg_addr_i == 8'h14 && !reg_wdata_i[1])
      next_run = reg_wdata_i[0];
    if (wr_ok && reg_addr_i == 8'h21)
      next_pulse = reg_wdata_i[6];
  end
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      en_q <= 1'b1;
      run_q <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      en_q <= next_en;
      run_q <= next_run;
      pulse_q <= next_pulse;
    end
  end
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  sequence sw_off;
    wr_ok && reg_addr_i == 8'h0e && !reg_wdata_i[7];
  endsequence
  sequence all_off;
    ##4 regulator_en_o == '0;
  endsequence
  a_bus_gated: assert property (!bus_active_o && reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read answered while bus inactive");
  a_por_bus: assert property ((!por_ok_i)[*3] |=> !bus_active_o)
    else $error("bus active without power good");
  a_supply_uv_off: assert property (sys_uv_i[*5] |-> regulator_en_o == '0)
    else $error("regulator on in supply undervoltage");
  a_input_uv_off: assert property ($stable(vin_uv_i)[*5] |->
    (regulator_en_o & vin_uv_i) == '0)
    else $error("regulator on in input undervoltage");
  a_discharge_off: assert property ($stable(regulator_en_o)[*3] |->
    (discharge_en_o & regulator_en_o) == '0)
    else $error("discharge on while regulator on");
  a_count_dir: assert property ($changed(slot_counter_o)
    && run_q == $past(run_q, 3) |-> (slot_counter_o > $past(slot_counter_o)) == run_q)
    else $error("slot counter moved the wrong way");
  a_sw_disable: assert property (sw_off |-> all_off)
    else $error("regulators kept on after software disable");
  a_disable_flag: assert property (sw_off ##0 (en_q && !pulse_q) |-> ##[3:4] irq_o)
    else $error("no interrupt on software disable entry");
  a_pulse_short: assert property (pulse_q && $past(pulse_q) && irq_o |=> !irq_o)
    else $error("pulse interrupt longer than one cycle");
endmodule
bind ldo_power_sequencer ldo_power_sequencer_checker #(.NUM_REG(NUM_REG)) chk (.clk_sys_i,
  .resetn_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .bus_active_o,
  .por_ok_i, .sys_uv_i, .vin_uv_i, .regulator_en_o, .discharge_en_o, .slot_counter_o, .irq_o);
`default_nettype wire

// >>> testbench/ldo_host_model.sv
// host side of the register port: single-cycle write and read strobes
// assumes the bench calls wr and rd one at a time
`timescale 1ns/1ns
`default_nettype none
module ldo_host_model (
  input wire logic clk_sys_i,
  input wire logic bus_active_i,
  input wire logic [7:0] reg_rdata_i,
  output var logic reg_wr_o,
  output var logic reg_rd_o,
  output var logic [7:0] reg_addr_o,
  output var logic [7:0] reg_wdata_o
);
  initial begin
    reg_wr_o <= 1'b0;
    reg_rd_o <= 1'b0;
    reg_addr_o <= 8'h00;
    reg_wdata_o <= 8'h00;
  end
  // bounded wait: a dead bus is still tried so refusals can be seen
  task automatic wait_bus();
    int n;
    for (n = 0; n < 8 && bus_active_i !== 1'b1; n++)
      @(posedge clk_sys_i);
  endtask
  // idle lines show the inverse of the last value, never a stale copy
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wait_bus();
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    wait_bus();
    @(posedge clk_sys_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge clk_sys_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    #1 d = reg_rdata_i;
  endtask
endmodule
`default_nettype wire

// >>> testbench/test_ldo_power_sequencer.sv
// self-checking bench for the regulator sequencer
// assumes the host model drives the register port and a short slot step
`timescale 1ns/1ns
`default_nettype none
module test_ldo_power_sequencer;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic por_ok_i = 1'b1;
  logic sys_uv_i = 1'b0;
  logic [6:0] vin_uv_i = 7'h00;
  logic overcurrent_i = 1'b0;
  logic overtemp_i = 1'b0;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [7:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic [7:0] reg_rdata_o;
  logic bus_active_o;
  logic [6:0] regulator_en_o;
  logic [6:0] discharge_en_o;
  logic [7:0] uv_threshold_o;
  logic [2:0] slot_counter_o;
  logic irq_o;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  // a three-cycle slot step keeps the sequencer runs short
  ldo_power_sequencer #(.STEP_CYCLES(3)) uut (.clk_sys_i, .resetn_i, .reg_wr_i, .reg_rd_i,
    .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .bus_active_o, .por_ok_i, .sys_uv_i, .vin_uv_i,
    .overcurrent_i, .overtemp_i, .regulator_en_o, .discharge_en_o, .uv_threshold_o,
    .slot_counter_o, .irq_o);
  ldo_host_model host (.clk_sys_i, .bus_active_i(bus_active_o), .reg_rdata_i(reg_rdata_o),
    .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));
  // ****************
  // helpers
  // ****************
  task automatic give_verdict();
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    check(d, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wait_cnt(input logic [2:0] v);
    int n;
    for (n = 0; n < 100 && slot_counter_o !== v; n++)
      cyc(1);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset_values();
    rchk(8'h02, 8'h00);
    rchk(8'h0e, 8'h80);
    rchk(8'h21, 8'h00);
    rchk(8'h24, 8'h00);
    rchk(8'h30, 8'h00);
    host.wr(8'h22, 8'hff);
    rchk(8'h22, 8'h00);
    check(uv_threshold_o, 8'h00);
    check({1'b0, discharge_en_o}, 8'h7f);
  endtask
  task automatic t_direct();
    host.wr(8'h0e, 8'h85);
    cyc(4);
    check({1'b0, regulator_en_o}, 8'h05);
    check({1'b0, discharge_en_o}, 8'h7a);
    host.wr(8'h02, 8'h7f);
    cyc(3);
    check({1'b0, discharge_en_o}, 8'h00);
    host.wr(8'h02, 8'h00);
    vin_uv_i <= 7'h04;
    cyc(5);
    check({1'b0, regulator_en_o}, 8'h01);
    vin_uv_i <= 7'h00;
  endtask
  task automatic t_supply();
    host.wr(8'h24, 8'h5a);
    cyc(3);
    check(uv_threshold_o, 8'h5a);
    @(posedge clk_sys_i);
    sys_uv_i <= 1'b1;
    overcurrent_i <= 1'b1;
    cyc(6);
    check({1'b0, regulator_en_o}, 8'h00);
    check({7'h00, irq_o}, 8'h01);
    rchk(8'h22, 8'h01);
    sys_uv_i <= 1'b0;
    cyc(3);
    host.wr(8'h23, 8'hff);
    cyc(6);
    rchk(8'h22, 8'h02);
    check({1'b0, regulator_en_o}, 8'h05);
    overcurrent_i <= 1'b0;
    host.wr(8'h23, 8'hff);
    cyc(4);
    rchk(8'h22, 8'h00);
    check({7'h00, irq_o}, 8'h00);
  endtask
  task automatic t_mask();
    host.wr(8'h21, 8'h01);
    sys_uv_i <= 1'b1;
    cyc(6);
    rchk(8'h22, 8'h00);
    sys_uv_i <= 1'b0;
    host.wr(8'h21, 8'h80);
    overtemp_i <= 1'b1;
    cyc(6);
    rchk(8'h22, 8'h00);
    host.wr(8'h21, 8'h04);
    cyc(6);
    rchk(8'h22, 8'h00);
    check({7'h00, irq_o}, 8'h00);
    host.wr(8'h21, 8'h00);
    cyc(6);
    rchk(8'h22, 8'h04);
    check({7'h00, irq_o}, 8'h01);
    overtemp_i <= 1'b0;
    host.wr(8'h21, 8'h40);
    host.wr(8'h23, 8'hff);
    overtemp_i <= 1'b1;
    cyc(3);
    check({7'h00, irq_o}, 8'h01);
    cyc(5);
    rchk(8'h22, 8'h04);
    check({7'h00, irq_o}, 8'h00);
    overtemp_i <= 1'b0;
    host.wr(8'h23, 8'hff);
    host.wr(8'h21, 8'h00);
  endtask
  task automatic t_sequence();
    host.wr(8'h10, 8'h71);
    host.wr(8'h14, 8'h01);
    wait_cnt(3'h6);
    check({1'b0, regulator_en_o}, 8'h05);
    wait_cnt(3'h7);
    cyc(12);
    check({1'b0, regulator_en_o}, 8'h07);
    check({5'h00, slot_counter_o}, 8'h07);
    host.wr(8'h14, 8'h02);
    cyc(12);
    check({5'h00, slot_counter_o}, 8'h07);
    host.wr(8'h14, 8'h00);
    wait_cnt(3'h2);
    check({1'b0, regulator_en_o}, 8'h05);
    wait_cnt(3'h0);
    cyc(12);
    check({1'b0, regulator_en_o}, 8'h04);
    check({5'h00, slot_counter_o}, 8'h00);
  endtask
  task automatic t_sw_disable();
    host.wr(8'h0e, 8'h05);
    cyc(4);
    check({1'b0, regulator_en_o}, 8'h00);
    rchk(8'h24, 8'h5a);
    rchk(8'h0e, 8'h05);
    rchk(8'h22, 8'h01);
    host.wr(8'h23, 8'hff);
    host.wr(8'h0e, 8'h85);
    cyc(4);
    rchk(8'h22, 8'h00);
    check({1'b0, regulator_en_o}, 8'h04);
  endtask
  task automatic t_hw_reset();
    por_ok_i <= 1'b0;
    sys_uv_i <= 1'b1;
    cyc(4);
    check({7'h00, bus_active_o}, 8'h00);
    host.wr(8'h24, 8'hff);
    rchk(8'h0e, 8'h00);
    check({7'h00, irq_o}, 8'h00);
    por_ok_i <= 1'b1;
    sys_uv_i <= 1'b0;
    cyc(6);
    rchk(8'h24, 8'h5a);
    rchk(8'h22, 8'h00);
    @(posedge clk_sys_i);
    resetn_i <= 1'b0;
    cyc(3);
    check({7'h00, bus_active_o}, 8'h00);
    check({1'b0, discharge_en_o}, 8'h7f);
    resetn_i <= 1'b1;
    cyc(4);
    check({7'h00, bus_active_o}, 8'h01);
    rchk(8'h24, 8'h00);
    rchk(8'h10, 8'h00);
    rchk(8'h0e, 8'h80);
  endtask
  // ****************
  // run
  // ****************
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    repeat (2) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    cyc(4);
    t_reset_values();
    t_direct();
    t_supply();
    t_mask();
    t_sequence();
    t_sw_disable();
    t_hw_reset();
    give_verdict();
  end
endmodule
`default_nettype wire
